// ---- design/usrb_fifo.sv ----
// synchronous first-in first-out store with head look-ahead
`timescale 1ns/1ns
module usrb_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned CW    = $clog2(DEPTH) + 1
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic             flush_i,  // drop all entries
  input  wire logic             push_i,   // ignored while full
  input  wire logic [WIDTH-1:0] din_i,
  input  wire logic             pop_i,    // ignored while empty
  output logic      [WIDTH-1:0] head_o,   // oldest entry
  output logic                  full_o,
  output logic                  empty_o,
  output logic      [CW-1:0]    count_o
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [PW-1:0]    wptr_r;       // next free slot
  logic [PW-1:0]    rptr_r;       // oldest slot
  logic [CW-1:0]    count_r;      // entries held
  logic             do_push;
  logic             do_pop;

  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;
  assign full_o  = (count_r == CW'(DEPTH));
  assign empty_o = (count_r == '0);
  assign head_o  = mem[rptr_r];
  assign count_o = count_r;

  // ==========================================================
  // pointers, wrapping at depth (depth need not be a power of 2)
  // ==========================================================
  always_ff @(posedge mclk_i) begin
    if (reset_i || flush_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (do_push) begin
        wptr_r <= (wptr_r == PW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (do_pop) begin
        rptr_r <= (rptr_r == PW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // occupancy
  // ==========================================================
  always_ff @(posedge mclk_i) begin
    if (reset_i || flush_i) begin
      count_r <= '0;
    end else if (do_push && !do_pop) begin
      count_r <= count_r + 1'b1;
    end else if (do_pop && !do_push) begin
      count_r <= count_r - 1'b1;
    end
  end

  // ==========================================================
  // storage, no reset needed
  // ==========================================================
  always_ff @(posedge mclk_i) begin
    if (do_push) begin
      mem[wptr_r] <= din_i;
    end
  end

endmodule : usrb_fifo

// ---- design/usrb_pkg.sv ----
// shared constants and types for the uart shadow receive/transmit alias
package usrb_pkg;

  // ==========================================================
  // widths and depths
  // ==========================================================
  localparam int unsigned DATA_W    = 8;   // character width
  localparam int unsigned REG_W     = 16;  // implemented register width
  localparam int unsigned BUS_W     = 32;  // bus data width
  localparam int unsigned ADDR_W    = 32;  // bus byte address width
  localparam int unsigned TX_DEPTH  = 16;  // transmit fifo depth
  localparam int unsigned RX_DEPTH  = 16;  // receive fifo depth
  localparam int unsigned WIN_WORDS = 16;  // words in the alias window

  // ==========================================================
  // byte addresses
  // ==========================================================
  localparam logic [31:0] WIN_BASE   = 32'h5000_1130; // alias word 0
  localparam logic [31:0] WIN_LAST   = 32'h5000_116C; // alias word 15
  localparam logic [31:0] ALIAS5_OFF = 32'h5000_1144; // alias word 5
  localparam logic [31:0] ALIAS6_OFF = 32'h5000_1148; // alias word 6
  localparam logic [31:0] CTRL_OFF   = 32'h5000_1180; // mode control
  localparam logic [31:0] LINE_OFF   = 32'h5000_1184; // line state
  localparam logic [31:0] ISTAT_OFF  = 32'h5000_1188; // sticky events
  localparam logic [31:0] IMASK_OFF  = 32'h5000_118C; // event mask

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int unsigned CTRL_FEN_BIT  = 0; // fifo enable
  localparam int unsigned CTRL_IR_BIT   = 1; // infrared mode
  localparam int unsigned LINE_DR_BIT   = 0; // data ready
  localparam int unsigned LINE_OVR_BIT  = 1; // overrun seen
  localparam int unsigned LINE_HOLDING_EMPTY_FLAG_BIT = 5; // holding empty
  localparam int unsigned EV_RXA_BIT    = 0; // byte accepted
  localparam int unsigned EV_OVR_BIT    = 1; // overrun
  localparam int unsigned EV_HOLDING_EMPTY_FLAG_BIT   = 2; // holding went empty
  localparam int unsigned EV_TXD_BIT    = 3; // write discarded
  localparam int unsigned EV_W          = 4; // event count

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [1:0]      CTRL_RST  = 2'h0;
  localparam logic [EV_W-1:0] ISTAT_RST = 4'h0;
  localparam logic [EV_W-1:0] IMASK_RST = 4'h0;
  localparam logic [BUS_W-1:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // types
  // ==========================================================
  // one character with its qualifier
  typedef struct packed {
    logic              vld;
    logic [DATA_W-1:0] data;
  } usrb_byte_t;

  // which line the character belongs to
  typedef enum logic {
    MODE_UART = 1'b0,
    MODE_IR   = 1'b1
  } usrb_mode_t;

endpackage : usrb_pkg

// ---- design/usrb_top.sv ----
// shadow alias window onto the receive buffer and transmit holding path
`timescale 1ns/1ns
module usrb_top #(
  parameter int unsigned TX_DEPTH = usrb_pkg::TX_DEPTH,
  parameter int unsigned RX_DEPTH = usrb_pkg::RX_DEPTH
) (
  input  wire logic                         mclk_i,
  input  wire logic                         reset_i,
  // register port
  input  wire logic [usrb_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [usrb_pkg::BUS_W-1:0]   wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [usrb_pkg::BUS_W-1:0]   rdata_o,
  // characters from the deserialisers
  input  wire usrb_pkg::usrb_byte_t         rx_uart_i,
  input  wire usrb_pkg::usrb_byte_t         rx_ir_i,
  // character to the serialiser
  output usrb_pkg::usrb_byte_t              tx_o,
  input  wire logic                         tx_take_i,
  output usrb_pkg::usrb_mode_t              tx_mode_o,
  // interrupt
  output logic                              irq_o
);

  localparam int unsigned DW  = usrb_pkg::DATA_W;
  localparam int unsigned EW  = usrb_pkg::EV_W;
  localparam int unsigned TCW = $clog2(TX_DEPTH) + 1;
  localparam int unsigned RCW = $clog2(RX_DEPTH) + 1;

  // ==========================================================
  // address decode helpers
  // ==========================================================
  // any aligned word of the sixteen-word alias window
  function automatic logic in_window(input logic [31:0] a);
    in_window = (a >= usrb_pkg::WIN_BASE) && (a <= usrb_pkg::WIN_LAST)
                && (a[1:0] == 2'h0);
  endfunction : in_window

  // line state word; each flag lands at its own bit position
  function automatic logic [31:0] line_word(input logic dr,
                                            input logic ovr,
                                            input logic empty);
    line_word                          = 32'h0000_0000;
    line_word[usrb_pkg::LINE_DR_BIT]   = dr;
    line_word[usrb_pkg::LINE_OVR_BIT]  = ovr;
    line_word[usrb_pkg::LINE_HOLDING_EMPTY_FLAG_BIT] = empty;
  endfunction : line_word

  // ==========================================================
  // declarations
  // ==========================================================
  logic [1:0]           ctrl_r;      // fifo enable, infrared mode
  logic [EW-1:0]        istat_r;     // sticky events
  logic [EW-1:0]        imask_r;     // event enables
  logic [EW-1:0]        ev;          // events this cycle
  logic [31:0]          rdata_r;     // registered read answer
  logic                 irq_r;       // interrupt level
  usrb_pkg::usrb_byte_t tx_r;        // character offered out
  usrb_pkg::usrb_mode_t mode_r;      // registered line mode
  logic [DW-1:0]        rx_hold_r;   // single receive buffer
  logic                 dr_r;        // single-buffer data ready
  logic                 holding_empty_flag_d_r;    // holding empty, last cycle
  usrb_pkg::usrb_byte_t rx_in;       // byte from selected line
  logic                 fen;         // fifos enabled
  logic                 fen_chg;     // fifo enable toggling
  logic                 wr_alias;    // write to any alias word
  logic                 rd_alias;    // read of any alias word
  logic                 rx_push;
  logic                 rx_pop;
  logic                 rx_full;
  logic                 rx_empty;
  logic [DW-1:0]        rx_head;
  logic [RCW-1:0]       rx_count;
  logic                 tx_push;
  logic                 tx_pop;
  logic                 tx_full;
  logic                 tx_empty;
  logic [DW-1:0]        tx_head;
  logic [TCW-1:0]       tx_count;
  logic                 tx_taken;    // serialiser consumed tx_r
  logic                 data_ready;  // line state data ready
  logic                 holding_empty_flag;        // line state holding empty
  logic                 ovr_ev;      // overrun this cycle
  logic [DW-1:0]        rd_byte;     // byte an alias read returns

  assign fen      = ctrl_r[usrb_pkg::CTRL_FEN_BIT];
  assign fen_chg  = wr_i && (addr_i == usrb_pkg::CTRL_OFF)
                    && (wdata_i[usrb_pkg::CTRL_FEN_BIT] != fen);
  assign wr_alias = wr_i && in_window(addr_i);
  assign rd_alias = rd_i && in_window(addr_i);
  assign tx_taken = tx_take_i && tx_r.vld;

  // ==========================================================
  // receive side
  // ==========================================================
  // the line the character came in on follows the mode bit
  assign rx_in = (mode_r == usrb_pkg::MODE_IR) ? rx_ir_i : rx_uart_i;

  assign rx_push = fen && rx_in.vld && !rx_full;
  assign rx_pop  = fen && rd_alias && !rx_empty;

  // overrun: single buffer still unread, or fifo already full
  assign ovr_ev = rx_in.vld
                  && ((!fen && dr_r && !rd_alias)
                      || (fen && rx_full));

  assign data_ready = fen ? !rx_empty : dr_r;
  assign rd_byte    = fen ? rx_head : rx_hold_r;

  // receive fifo, only written while fifos are on
  usrb_fifo #(
    .WIDTH (DW),
    .DEPTH (RX_DEPTH),
    .CW    (RCW)
  ) u_rx_fifo (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .flush_i (fen_chg),
    .push_i  (rx_push),
    .din_i   (rx_in.data),
    .pop_i   (rx_pop),
    .head_o  (rx_head),
    .full_o  (rx_full),
    .empty_o (rx_empty),
    .count_o (rx_count)
  );

  // single buffer: a new byte always lands, even over unread data
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rx_hold_r <= '0;
    end else if (!fen && rx_in.vld) begin
      rx_hold_r <= rx_in.data;
    end
  end

  // data ready for the single buffer; arrival beats a read
  always_ff @(posedge mclk_i) begin
    if (reset_i || fen_chg) begin
      dr_r <= 1'b0;
    end else if (!fen && rx_in.vld) begin
      dr_r <= 1'b1;
    end else if (rd_alias) begin
      dr_r <= 1'b0;
    end
  end

  // ==========================================================
  // transmit side
  // ==========================================================
  // full fifo drops the write, contents stay
  assign tx_push = fen && wr_alias && !tx_full;
  // refill the output stage when it is free or being emptied
  assign tx_pop  = fen && !tx_empty && (!tx_r.vld || tx_take_i);
  assign holding_empty_flag    = fen ? tx_empty : !tx_r.vld;

  usrb_fifo #(
    .WIDTH (DW),
    .DEPTH (TX_DEPTH),
    .CW    (TCW)
  ) u_tx_fifo (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .flush_i (fen_chg),
    .push_i  (tx_push),
    .din_i   (wdata_i[DW-1:0]),  // 31:8 dropped
    .pop_i   (tx_pop),
    .head_o  (tx_head),
    .full_o  (tx_full),
    .empty_o (tx_empty),
    .count_o (tx_count)
  );

  // output stage; without fifos it is the holding register itself
  always_ff @(posedge mclk_i) begin
    if (reset_i || fen_chg) begin
      tx_r <= '0;
    end else if (!fen && wr_alias) begin
      // a second write before the take replaces the first
      tx_r.vld  <= 1'b1;
      tx_r.data <= wdata_i[DW-1:0];
    end else if (tx_pop) begin
      tx_r.vld  <= 1'b1;
      tx_r.data <= tx_head;
    end else if (tx_taken) begin
      tx_r.vld  <= 1'b0;
    end
  end

  // line choice for the serialiser
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mode_r <= usrb_pkg::MODE_UART;
    end else begin
      mode_r <= usrb_pkg::usrb_mode_t'(ctrl_r[usrb_pkg::CTRL_IR_BIT]);
    end
  end

  // ==========================================================
  // control register
  // ==========================================================
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_r <= usrb_pkg::CTRL_RST;
    end else if (wr_i && addr_i == usrb_pkg::CTRL_OFF) begin
      ctrl_r <= wdata_i[1:0];
    end
  end

  // ==========================================================
  // events, sticky status and mask
  // ==========================================================
  always_comb begin
    ev                          = '0;
    ev[usrb_pkg::EV_RXA_BIT]    = rx_in.vld && !ovr_ev;
    ev[usrb_pkg::EV_OVR_BIT]    = ovr_ev;
    ev[usrb_pkg::EV_HOLDING_EMPTY_FLAG_BIT]   = holding_empty_flag && !holding_empty_flag_d_r;
    ev[usrb_pkg::EV_TXD_BIT]    = fen && wr_alias && tx_full;
  end

  // rising edge detect of holding empty
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      holding_empty_flag_d_r <= 1'b1;
    end else begin
      holding_empty_flag_d_r <= holding_empty_flag;
    end
  end

  // write one clears; a new event in the same cycle wins
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      istat_r <= usrb_pkg::ISTAT_RST;
    end else if (wr_i && addr_i == usrb_pkg::ISTAT_OFF) begin
      istat_r <= (istat_r & ~wdata_i[EW-1:0]) | ev;
    end else begin
      istat_r <= istat_r | ev;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      imask_r <= usrb_pkg::IMASK_RST;
    end else if (wr_i && addr_i == usrb_pkg::IMASK_OFF) begin
      imask_r <= wdata_i[EW-1:0];
    end
  end

  // level output, one cycle behind the status
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(istat_r & imask_r);
    end
  end

  // ==========================================================
  // read answer, valid the cycle after the strobe only
  // ==========================================================
  always_ff @(posedge mclk_i) begin
    if (reset_i || !rd_i) begin
      rdata_r <= usrb_pkg::RDATA_RST;
    end else if (rd_alias) begin
      rdata_r <= {24'h00_0000, rd_byte};  // upper bits zero
    end else begin
      case (addr_i)
        usrb_pkg::CTRL_OFF:  rdata_r <= {30'h0000_0000, ctrl_r};
        usrb_pkg::LINE_OFF:  rdata_r <= line_word(data_ready,
                                         istat_r[usrb_pkg::EV_OVR_BIT], holding_empty_flag);
        usrb_pkg::ISTAT_OFF: rdata_r <= {28'h000_0000, istat_r};
        usrb_pkg::IMASK_OFF: rdata_r <= {28'h000_0000, imask_r};
        default:             rdata_r <= usrb_pkg::RDATA_RST;
      endcase
    end
  end

  assign rdata_o   = rdata_r;
  assign tx_o      = tx_r;
  assign tx_mode_o = mode_r;
  assign irq_o     = irq_r;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  chk_alias_any_word: assert property (
    rd_alias && !fen && dr_r && !rx_in.vld && !fen_chg |=> !dr_r)
    else $error("alias read did not consume the single buffer");

  chk_read_single: assert property (
    rd_alias && !fen |=> rdata_o[7:0] == $past(rx_hold_r))
    else $error("alias read gave wrong received byte");

  chk_overrun_overwrite: assert property (
    !fen && rx_in.vld && dr_r && !rd_alias && !fen_chg
    |=> istat_r[usrb_pkg::EV_OVR_BIT] && rx_hold_r == $past(rx_in.data))
    else $error("single buffer overrun not handled");

  chk_read_head: assert property (
    rd_alias && fen && !rx_empty
    |=> rdata_o[7:0] == $past(rx_head) && rx_count == $past(rx_count)
        - RCW'(1) + RCW'($past(rx_push)))
    else $error("alias read did not take fifo head");

  chk_rx_full_drop: assert property (
    fen && rx_in.vld && rx_full && !rx_pop && !fen_chg
    |=> rx_full && istat_r[usrb_pkg::EV_OVR_BIT])
    else $error("full receive fifo accepted a byte");

  chk_tx_queue: assert property (
    wr_alias && !fen && !fen_chg
    |=> tx_o.vld && tx_o.data == $past(wdata_i[7:0]))
    else $error("written byte not offered to serialiser");

  chk_holding_clear: assert property (
    wr_alias && !fen && !fen_chg |=> !holding_empty_flag && tx_o.vld)
    else $error("holding empty still set after write");

  chk_tx_depth: assert property (
    wr_alias && fen && !tx_full && !fen_chg
    |=> tx_count == $past(tx_count) + TCW'(1) - TCW'($past(tx_pop)))
    else $error("transmit fifo did not take write");

  chk_tx_full_drop: assert property (
    wr_alias && fen && tx_full && !tx_pop && !fen_chg
    |=> tx_count == $past(tx_count) && istat_r[usrb_pkg::EV_TXD_BIT])
    else $error("full transmit fifo changed on write");

  chk_reserved_zero: assert property (
    rd_alias |=> rdata_o[15:8] == 8'h00)
    else $error("reserved alias bits read nonzero");

  cov_rx_overrun:  cover property (rx_in.vld && fen && rx_full);
  cov_tx_full:     cover property (wr_alias && fen && tx_full);
  cov_alias5_read: cover property (rd_i && addr_i == usrb_pkg::ALIAS5_OFF
                                   ##1 rd_i
                                   && addr_i == usrb_pkg::ALIAS6_OFF);
  cov_irq:         cover property ($rose(irq_o));
  cov_tx_rewrite:  cover property (wr_alias && !fen && tx_o.vld);

endmodule : usrb_top

// ---- test/testbench.sv ----
// self-checking bench for the shadow alias window
`timescale 1ns/1ns
module testbench;
  localparam int unsigned TXD = 4; // shortened depths
  localparam int unsigned RXD = 4;
  logic                 mclk_i = 1'b0;
  logic                 reset_i = 1'b1;
  logic [31:0]          addr_i = '0, wdata_i = '0;
  logic                 wr_i = 1'b0, rd_i = 1'b0;
  logic [31:0]          rdata_o;
  usrb_pkg::usrb_byte_t rx_uart, rx_ir, tx_o, taken;
  usrb_pkg::usrb_mode_t tx_mode_o;
  logic                 irq_o, take, send = 1'b0, stall = 1'b0;
  logic [7:0]           send_data = '0;
  integer               mismatches = 0, samples_checked = 0, cycles = 0;
  integer               seed = 32'hbb245421;
  logic [31:0]          d, d2;
  logic [7:0]           v [0:7];  // random characters
  logic [7:0]           got [$];  // bytes taken by serialiser
  always #2 mclk_i = ~mclk_i;
  usrb_top #(.TX_DEPTH(TXD), .RX_DEPTH(RXD)) i_usrb_top (
    .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_uart_i(rx_uart), .rx_ir_i(rx_ir), .tx_o(tx_o),
    .tx_take_i(take), .tx_mode_o(tx_mode_o), .irq_o(irq_o));
  usrb_line_model i_usrb_line_model (
    .mclk_i(mclk_i), .reset_i(reset_i), .send_i(send),
    .send_data_i(send_data), .stall_i(stall), .tx_i(tx_o),
    .mode_i(tx_mode_o), .rx_uart_o(rx_uart), .rx_ir_o(rx_ir),
    .take_o(take), .taken_o(taken));
  // ==========================================================
  // helpers
  // ==========================================================
  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic check(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wr(input logic [31:0] a, input logic [31:0] w);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= w;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 r = rdata_o;
  endtask : rd
  // two reads back to back; each answer stands one cycle only
  task automatic rd2(input logic [31:0] a, b, output logic [31:0] r0, r1);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    addr_i <= b;
    #1 r0 = rdata_o;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 r1 = rdata_o;
  endtask : rd2
  task automatic put(input logic [7:0] b);
    @(posedge mclk_i);
    send <= 1'b1;
    send_data <= b;
    @(posedge mclk_i);
    send <= 1'b0;
  endtask : put
  // any of the sixteen words, chosen at random
  function automatic logic [31:0] alias_a();
    return usrb_pkg::WIN_BASE + {$random(seed) & 32'hF, 2'b00};
  endfunction : alias_a
  always @(posedge mclk_i) begin
    if (taken.vld === 1'b1) got.push_back(taken.data);
    cycles <= cycles + 1;
    if (cycles == 20000) begin // hang guard
      mismatches++;
      final_report();
    end
  end
  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    for (int i = 0; i < 8; i++) v[i] = $random(seed);
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(usrb_pkg::CTRL_OFF, d);
    check("ctrl rst", d, 32'h0);
    rd(usrb_pkg::LINE_OFF, d);
    check("line rst", d, 32'h20);
    rd(usrb_pkg::IMASK_OFF, d);
    check("imask rst", d, 32'h0);
    rd(32'h5000_1170, d);
    check("unmapped", d, 32'h0);
    // fifo off: read, then overwrite with overrun
    put(v[0]);
    rd(usrb_pkg::LINE_OFF, d);
    check("dr", d[0], 1'b1);
    rd(alias_a(), d);
    check("rx byte", d, {24'h0, v[0]});
    put(v[1]);
    put(v[2]);
    rd(usrb_pkg::LINE_OFF, d);
    check("ovr off", d[1:0], 2'h3);
    rd(alias_a(), d);
    check("rx last", d, {24'h0, v[2]});
    // fifo off transmit: second write overwrites pending data
    stall <= 1'b1;
    wr(alias_a(), {16'h0, 8'hA5, v[3]});
    wr(alias_a(), {16'hFFFF, 8'hFF, v[4]});
    #1 check("tx hold", {23'h0, tx_o}, {23'h1, v[4]});
    rd(usrb_pkg::LINE_OFF, d);
    check("holding_empty_flag lo", d[5], 1'b0);
    got.delete();
    stall <= 1'b0;
    repeat (8) @(posedge mclk_i);
    check("tx n", got.size(), 1);
    check("tx out", got[0], v[4]);
    rd(usrb_pkg::LINE_OFF, d);
    check("holding_empty_flag hi", d[5], 1'b1);
    // fifo on receive: fill past depth, drop newest
    wr(usrb_pkg::ISTAT_OFF, 32'hF);
    wr(usrb_pkg::CTRL_OFF, 32'h1);
    for (int i = 0; i <= RXD; i++) put(v[i]);
    rd(usrb_pkg::ISTAT_OFF, d);
    check("ovr on", d[1], 1'b1);
    for (int i = 0; i < RXD; i++) begin
      rd(alias_a(), d);
      check("rx head", d, {24'h0, v[i]});
    end
    rd(usrb_pkg::LINE_OFF, d);
    check("dr empty", d[0], 1'b0);
    // burst: two different alias words read with no gap
    put(v[6]);
    put(v[7]);
    rd2(usrb_pkg::ALIAS5_OFF, usrb_pkg::ALIAS6_OFF, d, d2);
    check("burst a", d, {24'h0, v[6]});
    check("burst b", d2, {24'h0, v[7]});
    // fifo on transmit: depth plus stage accepted, rest lost
    stall <= 1'b1;
    got.delete();
    for (int i = 0; i < TXD + 2; i++) wr(alias_a(), {24'h0, v[i]});
    rd(usrb_pkg::ISTAT_OFF, d);
    check("tx drop", d[3], 1'b1);
    stall <= 1'b0;
    repeat (40) @(posedge mclk_i);
    check("tx cnt", got.size(), TXD + 1);
    for (int i = 0; i <= TXD; i++) check("tx seq", got[i], v[i]);
    // infrared mode, fifo off
    wr(usrb_pkg::CTRL_OFF, 32'h2);
    repeat (2) @(posedge mclk_i);
    check("mode", tx_mode_o, usrb_pkg::MODE_IR);
    put(v[5]);
    rd(alias_a(), d);
    check("ir byte", d, {24'h0, v[5]});
    // interrupt: raise, clear, mask
    wr(usrb_pkg::ISTAT_OFF, 32'hF);
    wr(usrb_pkg::IMASK_OFF, 32'h1);
    put(v[6]);
    repeat (3) @(posedge mclk_i);
    #1 check("irq on", irq_o, 1'b1);
    wr(usrb_pkg::ISTAT_OFF, 32'h1);
    repeat (2) @(posedge mclk_i);
    #1 check("irq clr", irq_o, 1'b0);
    wr(usrb_pkg::IMASK_OFF, 32'h0);
    put(v[7]);
    repeat (3) @(posedge mclk_i);
    #1 check("irq mask", irq_o, 1'b0);
    final_report();
  end
endmodule : testbench

// ---- test/usrb_line_model.sv ----
// line side model: deserialisers offering bytes, serialiser taking them
`timescale 1ns/1ns
module usrb_line_model (
  input  wire logic                 mclk_i,
  input  wire logic                 reset_i,
  input  wire logic                 send_i,      // offer one byte now
  input  wire logic [7:0]           send_data_i, // byte to offer
  input  wire logic                 stall_i,     // slow serialiser
  input  wire usrb_pkg::usrb_byte_t tx_i,        // offered character
  input  wire usrb_pkg::usrb_mode_t mode_i,      // active line
  output usrb_pkg::usrb_byte_t      rx_uart_o,   // uart deserialiser
  output usrb_pkg::usrb_byte_t      rx_ir_o,     // infrared deserialiser
  output logic                      take_o,      // consume pulse
  output usrb_pkg::usrb_byte_t      taken_o      // byte just consumed
);
  // ==========================================================
  // receive lines
  // ==========================================================
  logic [7:0] noise_r; // idle data changes every cycle, never stale
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      noise_r <= 8'h00;
    end else begin
      noise_r <= noise_r + 8'h3B;
    end
  end
  // only the line chosen by mode carries the byte
  assign rx_uart_o = (mode_i == usrb_pkg::MODE_UART && send_i) ?
                     {1'b1, send_data_i} : {1'b0, noise_r};
  assign rx_ir_o   = (mode_i == usrb_pkg::MODE_IR && send_i) ?
                     {1'b1, send_data_i} : {1'b0, ~noise_r};
  // ==========================================================
  // serialiser
  // ==========================================================
  // one take per offer, a gap after it, stalls when told
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      take_o  <= 1'b0;
      taken_o <= '0;
    end else begin
      take_o  <= tx_i.vld & ~stall_i & ~take_o;
      taken_o <= {take_o & tx_i.vld, tx_i.data};
    end
  end
endmodule : usrb_line_model
